// ==== common/swu_pkg.sv ====
// constants and types for the suspend and warm-up sequencer
// How it works
// - power-down request bit 1 stops all clocks
// - idle request bit 0 freezes cpu clock
// - interrupt or reset clears both request bits
// - bits 3-2 are plain software flags
// - bit 6 selects serial control upper view
// - host writes key 55H then mode bit
// - non-consecutive sequence clears key, no suspend
// - host writes 01H or 02H, then three nops
// - 8-bit key register, zero after reset
// - power warm-up first, then oscillator warm-up
// - 11ms for resets, 64 counts for wake
// - watchdog reset 1000 counts, osc only from sleep
// - power warm-up counts on 2MHz rc tick
// - crystal warm-up 2^17/2^14/2^11/2^8 periods
// - internal rc warm-up always 2^7 periods
// - oscillator type codes 0000, 0001, 1110
// - watchdog enable, sleep option needs enable
// - clock monitor option during warm-up
// - overrange gives interrupt at 1, reset at 0
// - undervoltage reset enable and level select
// - reset pin option: reset or port pin
// - both bits set: power-down only, clear both
// - external irq wakes from power-down
package swu_pkg;
  localparam logic [7:0] SWU_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SWU_ADDR_SUSPEND_KEY   = 8'h8E;
  localparam logic [7:0] SWU_KEY_VALUE          = 8'h55;
  localparam logic [7:0] SWU_KEY_RESET          = 8'h00;
  localparam logic [7:0] SWU_POWER_CONTROL_RESET         = 8'h00;
  localparam logic [7:0] SWU_IDLE_OR            = 8'h01;
  localparam logic [7:0] SWU_PD_OR              = 8'h02;
  localparam int SWU_BIT_IDLE   = 0;
  localparam int SWU_BIT_PD     = 1;
  localparam int SWU_BIT_GF_LO  = 2;
  localparam int SWU_BIT_GF_HI  = 3;
  localparam int SWU_BIT_SERIAL_CTRL_VIEW_SELECT  = 6;
  localparam int SWU_BIT_SMOD   = 7;
  localparam logic [7:0] SWU_POWER_CONTROL_WMASK = 8'hCF;
  localparam int SWU_NOP_COUNT  = 3;
  localparam int SWU_CLK_MHZ    = 125;
  localparam int SWU_RC_KHZ     = 2000;
  localparam int SWU_RC_DIV = (SWU_CLK_MHZ * 1000 + SWU_RC_KHZ - 1)
                              / SWU_RC_KHZ;
  localparam int SWU_PWR_LONG_US = 11000;
  localparam int SWU_PWR_LONG_CKS = SWU_PWR_LONG_US * SWU_RC_KHZ / 1000;
  localparam int SWU_PWR_WDT_CKS  = 1000;
  localparam int SWU_PWR_WAKE_CKS = 64;
  localparam int SWU_OSC_XTAL_EXP0 = 17;
  localparam int SWU_OSC_XTAL_EXP1 = 14;
  localparam int SWU_OSC_XTAL_EXP2 = 11;
  localparam int SWU_OSC_XTAL_EXP3 = 8;
  localparam int SWU_OSC_RC_EXP    = 7;
  localparam logic [3:0] SWU_OSC_RC12  = 4'h0;
  localparam logic [3:0] SWU_OSC_RC16  = 4'h1;
  localparam logic [3:0] SWU_OSC_XTAL  = 4'hE;
  localparam logic [1:0] SWU_WMT_RESET = 2'h0;
  typedef enum logic [1:0] {
    SWU_OSC_KIND_RC12 = 2'b00,
    SWU_OSC_KIND_RC16 = 2'b01,
    SWU_OSC_KIND_XTAL = 2'b10
  } swu_osc_kind_t;
  typedef enum logic [2:0] {
    SWU_ST_RUN   = 3'b000,
    SWU_ST_IDLE  = 3'b001,
    SWU_ST_SLEEP = 3'b010,
    SWU_ST_PWR   = 3'b011,
    SWU_ST_OSC   = 3'b100
  } swu_state_t;
  typedef enum logic [1:0] {
    SWU_SRC_COLD = 2'b00,
    SWU_SRC_WDT  = 2'b01,
    SWU_SRC_WAKE = 2'b10
  } swu_src_t;
endpackage

// ==== common/swu_if.sv ====
// interface joining cpu-side host and the sequencer device
`timescale 1ns/10ps
interface swu_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       instr_end;
  logic [7:0] rdata;
  logic       cpu_clk_en;
  logic       cpu_hold;
  logic       periph_clk_en;
  logic       sleeping;
  modport device (
    input  wr_en, rd_en, addr, wdata, instr_end,
    output rdata, cpu_clk_en, cpu_hold, periph_clk_en, sleeping
  );
  modport host (
    output wr_en, rd_en, addr, wdata, instr_end,
    input  rdata, cpu_clk_en, cpu_hold, periph_clk_en, sleeping
  );
endinterface

// ==== hdl/swu_device.sv ====
// suspend control registers and warm-up sequencer
`timescale 1ns/10ps
module swu_device
  import swu_pkg::*;
#(
  parameter int PWR_LONG_CKS = SWU_PWR_LONG_CKS,
  parameter int RC_DIV       = SWU_RC_DIV
) (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  swu_if.device           bus,
  input  wire logic       i_irq,
  input  wire logic       i_ext_irq_zero,
  input  wire logic       i_wdt_overflow,
  input  wire logic       i_pc_overrange_event,
  input  wire logic       i_undervoltage_low,
  input  wire logic       i_pin_reset_n,
  input  wire logic [3:0] i_osc_type_option,
  input  wire logic [1:0] i_osc_warmup_length_option,
  input  wire logic       i_watchdog_enable_option,
  input  wire logic       i_watchdog_in_sleep_option,
  input  wire logic       i_clock_monitor_warmup_option,
  input  wire logic       i_overrange_action_option,
  input  wire logic       i_undervoltage_enable_option,
  input  wire logic       i_undervoltage_level_option,
  input  wire logic       i_reset_pin_option,
  output logic            o_watchdog_run,
  output logic            o_clock_monitor_on,
  output logic            o_overrange_irq,
  output logic            o_undervoltage_level,
  output logic            o_shared_port_in,
  output logic            o_serial_ctrl_view_select,
  output logic [1:0]      o_software_flags,
  output logic            o_osc_enable,
  output logic            o_cpu_reset
);
  localparam int PW = 32;
  logic [1:0] pin_sync_reg, uv_sync_reg, ext_sync_reg;
  logic [7:0] key_reg, key_next, power_control_reg, power_control_next;
  logic       armed_reg;
  swu_state_t state_reg, state_next;
  swu_src_t   src_reg;
  logic [PW-1:0] cnt_reg;
  logic [$clog2(RC_DIV+1)-1:0] div_reg;
  logic [3:0] osc_sel_reg;
  logic       osc_needed_reg;
  logic       rc_tick, pin_rst, uv_rst, wdt_rst, ovl_rst, any_rst;
  logic       wr_key, wr_power_control, mode_set, warm;
  logic       cnt_done, wake_ev;
  logic       wdt_only;
  swu_state_t state_out;
  logic [7:0] power_control_out;
  logic [PW-1:0] pwr_len, osc_len;
  swu_osc_kind_t osc_kind;
  function automatic swu_osc_kind_t osc_decode(input logic [3:0] code);
    case (code)
      SWU_OSC_RC16: osc_decode = SWU_OSC_KIND_RC16;
      SWU_OSC_XTAL: osc_decode = SWU_OSC_KIND_XTAL;
      default:      osc_decode = SWU_OSC_KIND_RC12;
    endcase
  endfunction
  function automatic logic [PW-1:0] osc_periods(input swu_osc_kind_t k,
                                                input logic [1:0] w);
    if (k != SWU_OSC_KIND_XTAL) begin
      osc_periods = PW'(1) << SWU_OSC_RC_EXP;
    end else begin
      case (w)
        2'h0:    osc_periods = PW'(1) << SWU_OSC_XTAL_EXP0;
        2'h1:    osc_periods = PW'(1) << SWU_OSC_XTAL_EXP1;
        2'h2:    osc_periods = PW'(1) << SWU_OSC_XTAL_EXP2;
        default: osc_periods = PW'(1) << SWU_OSC_XTAL_EXP3;
      endcase
    end
  endfunction
  assign osc_kind = osc_decode(osc_sel_reg);
  assign osc_len  = osc_periods(osc_kind, i_osc_warmup_length_option);
  assign pin_rst  = ~i_reset_pin_option & ~pin_sync_reg[1];
  assign uv_rst   = i_undervoltage_enable_option & uv_sync_reg[1];
  assign wdt_rst  = i_watchdog_enable_option & i_wdt_overflow &
                    (state_reg != SWU_ST_SLEEP |
                     i_watchdog_in_sleep_option);
  assign ovl_rst  = ~i_overrange_action_option &
                    i_pc_overrange_event;
  assign any_rst  = pin_rst | uv_rst | wdt_rst | ovl_rst;
  assign wake_ev  = ext_sync_reg[1] | i_irq;
  assign warm     = state_reg == SWU_ST_PWR | state_reg == SWU_ST_OSC;
  assign wr_key   = bus.wr_en & bus.addr == SWU_ADDR_SUSPEND_KEY & ~warm;
  assign wr_power_control  = bus.wr_en & bus.addr == SWU_ADDR_POWER_CONTROL & ~warm;
  assign mode_set = wr_power_control &
                    (bus.wdata[SWU_BIT_PD] | bus.wdata[SWU_BIT_IDLE]);
  assign rc_tick  = div_reg == '0;
  assign cnt_done = cnt_reg == '0;
  assign wdt_only = wdt_rst & ~pin_rst & ~uv_rst;
  assign pwr_len  = wdt_only ? PW'(SWU_PWR_WDT_CKS)
                             : PW'(PWR_LONG_CKS);
  // outputs follow a reset at once, so no stray cpu clock cycle
  assign state_out = any_rst ? SWU_ST_PWR : state_next;
  assign power_control_out  = any_rst ? SWU_POWER_CONTROL_RESET : power_control_next;
  always_comb begin
    key_next  = key_reg;
    power_control_next = power_control_reg;
    if (wr_key) key_next = bus.wdata;
    if (wr_power_control) begin
      power_control_next = bus.wdata & SWU_POWER_CONTROL_WMASK;
    end
    if (bus.instr_end & armed_reg & ~wr_power_control) begin
      key_next = SWU_KEY_RESET;
    end
    if (mode_set & ~(armed_reg & key_reg == SWU_KEY_VALUE)) begin
      power_control_next[SWU_BIT_PD]   = 1'b0;
      power_control_next[SWU_BIT_IDLE] = 1'b0;
    end
    if (wake_ev & state_reg != SWU_ST_RUN) begin
      power_control_next[SWU_BIT_PD]   = 1'b0;
      power_control_next[SWU_BIT_IDLE] = 1'b0;
      key_next = SWU_KEY_RESET;
    end
  end
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWU_ST_RUN: begin
        if (power_control_reg[SWU_BIT_PD]) state_next = SWU_ST_SLEEP;
        else if (power_control_reg[SWU_BIT_IDLE]) state_next = SWU_ST_IDLE;
      end
      SWU_ST_IDLE:  if (wake_ev) state_next = SWU_ST_RUN;
      SWU_ST_SLEEP: if (ext_sync_reg[1]) state_next = SWU_ST_PWR;
      SWU_ST_PWR: if (rc_tick & cnt_done) begin
        state_next = osc_needed_reg ? SWU_ST_OSC : SWU_ST_RUN;
      end
      SWU_ST_OSC: if (cnt_done) state_next = SWU_ST_RUN;
      default: state_next = SWU_ST_RUN;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_sync_reg <= 2'b11;
      uv_sync_reg  <= 2'b00;
      ext_sync_reg <= 2'b00;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], i_pin_reset_n};
      uv_sync_reg  <= {uv_sync_reg[0], i_undervoltage_low};
      ext_sync_reg <= {ext_sync_reg[0], i_ext_irq_zero};
    end
  end
  // any reset restarts the sequence; power_control and key return to zero
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      key_reg   <= SWU_KEY_RESET;
      power_control_reg  <= SWU_POWER_CONTROL_RESET;
      armed_reg <= 1'b0;
      osc_sel_reg <= SWU_OSC_RC12;
    end else if (any_rst) begin
      key_reg   <= SWU_KEY_RESET;
      power_control_reg  <= SWU_POWER_CONTROL_RESET;
      armed_reg <= 1'b0;
    end else begin
      key_reg   <= key_next;
      power_control_reg  <= power_control_next;
      if (wr_key) armed_reg <= bus.wdata == SWU_KEY_VALUE;
      else if (bus.instr_end) armed_reg <= 1'b0;
      // options are sampled once the cpu is held, so a change cannot
      // corrupt a running warm-up
      if (state_reg == SWU_ST_PWR) osc_sel_reg <= i_osc_type_option;
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg      <= SWU_ST_PWR;
      src_reg        <= SWU_SRC_COLD;
      osc_needed_reg <= 1'b1;
      cnt_reg        <= PW'(PWR_LONG_CKS);
      div_reg        <= '0;
    end else if (any_rst) begin
      state_reg      <= SWU_ST_PWR;
      src_reg        <= wdt_only ? SWU_SRC_WDT : SWU_SRC_COLD;
      osc_needed_reg <= ~wdt_only | state_reg == SWU_ST_SLEEP;
      cnt_reg        <= pwr_len;
      div_reg        <= '0;
    end else begin
      state_reg <= state_next;
      div_reg   <= rc_tick ? ($bits(div_reg))'(RC_DIV - 1)
                           : div_reg - 1'b1;
      if (state_reg == SWU_ST_SLEEP & state_next == SWU_ST_PWR) begin
        src_reg        <= SWU_SRC_WAKE;
        osc_needed_reg <= 1'b1;
        cnt_reg        <= PW'(SWU_PWR_WAKE_CKS);
      end else if (state_reg == SWU_ST_PWR & state_next == SWU_ST_OSC) begin
        cnt_reg <= osc_len;
      end else if (state_reg == SWU_ST_PWR & rc_tick & ~cnt_done) begin
        cnt_reg <= cnt_reg - 1'b1;
      end else if (state_reg == SWU_ST_OSC & ~cnt_done) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.rdata         <= 8'h00;
      bus.cpu_clk_en    <= 1'b0;
      bus.cpu_hold      <= 1'b1;
      bus.periph_clk_en <= 1'b0;
      bus.sleeping      <= 1'b0;
      o_watchdog_run    <= 1'b0;
      o_clock_monitor_on <= 1'b1;
      o_overrange_irq   <= 1'b0;
      o_undervoltage_level <= 1'b0;
      o_shared_port_in  <= 1'b1;
      o_serial_ctrl_view_select <= 1'b0;
      o_software_flags  <= 2'b00;
      o_osc_enable      <= 1'b0;
      o_cpu_reset       <= 1'b1;
    end else begin
      bus.rdata <= bus.rd_en & bus.addr == SWU_ADDR_SUSPEND_KEY ? key_reg :
                   bus.rd_en & bus.addr == SWU_ADDR_POWER_CONTROL ?
                   power_control_reg : 8'h00;
      bus.cpu_clk_en    <= state_out == SWU_ST_RUN;
      bus.cpu_hold      <= state_out == SWU_ST_PWR |
                           state_out == SWU_ST_OSC;
      bus.periph_clk_en <= state_out == SWU_ST_RUN |
                           state_out == SWU_ST_IDLE;
      bus.sleeping      <= state_out == SWU_ST_SLEEP;
      o_watchdog_run    <= i_watchdog_enable_option &
                           (state_out != SWU_ST_SLEEP |
                            i_watchdog_in_sleep_option);
      o_clock_monitor_on <= ~(warm & i_clock_monitor_warmup_option);
      o_overrange_irq   <= i_overrange_action_option &
                           i_pc_overrange_event;
      o_undervoltage_level <= i_undervoltage_level_option;
      o_shared_port_in  <= pin_sync_reg[1] | ~i_reset_pin_option;
      o_serial_ctrl_view_select <= power_control_out[SWU_BIT_SERIAL_CTRL_VIEW_SELECT];
      o_software_flags  <= power_control_out[SWU_BIT_GF_HI:SWU_BIT_GF_LO];
      o_osc_enable      <= state_out != SWU_ST_SLEEP &
                           state_out != SWU_ST_PWR;
      o_cpu_reset       <= any_rst |
                           (o_cpu_reset & state_out != SWU_ST_RUN &
                            src_reg != SWU_SRC_WAKE);
    end
  end
endmodule

// ==== hdl/swu_host.sv ====
// cpu-side sequencer that issues the keyed suspend sequence
`timescale 1ns/10ps
module swu_host
  import swu_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  swu_if.host             bus,
  input  wire logic       i_go,
  input  wire logic       i_powerdown,
  output logic            o_busy,
  output logic            o_suspended
);
  typedef enum logic [1:0] {
    SWU_H_IDLE = 2'b00,
    SWU_H_KEY  = 2'b01,
    SWU_H_MODE = 2'b10,
    SWU_H_NOP  = 2'b11
  } swu_hstate_t;
  swu_hstate_t st_reg;
  logic [1:0]  nop_reg;
  logic        pd_reg;
  logic        can_go;
  assign can_go = i_go & bus.cpu_clk_en & ~bus.cpu_hold;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg        <= SWU_H_IDLE;
      nop_reg       <= 2'd0;
      pd_reg        <= 1'b0;
      bus.wr_en     <= 1'b0;
      bus.rd_en     <= 1'b0;
      bus.addr      <= 8'h00;
      bus.wdata     <= 8'h00;
      bus.instr_end <= 1'b0;
      o_busy        <= 1'b0;
      o_suspended   <= 1'b0;
    end else begin
      bus.wr_en     <= 1'b0;
      bus.instr_end <= 1'b0;
      o_suspended   <= ~bus.cpu_clk_en;
      case (st_reg)
        SWU_H_IDLE: if (can_go) begin
          st_reg <= SWU_H_KEY;
          pd_reg <= i_powerdown;
          o_busy <= 1'b1;
        end
        SWU_H_KEY: begin
          bus.wr_en     <= 1'b1;
          bus.addr      <= SWU_ADDR_SUSPEND_KEY;
          bus.wdata     <= SWU_KEY_VALUE;
          bus.instr_end <= 1'b1;
          st_reg        <= SWU_H_MODE;
        end
        SWU_H_MODE: begin
          bus.wr_en     <= 1'b1;
          bus.addr      <= SWU_ADDR_POWER_CONTROL;
          bus.wdata     <= pd_reg ? SWU_PD_OR : SWU_IDLE_OR;
          bus.instr_end <= 1'b1;
          nop_reg       <= 2'(SWU_NOP_COUNT);
          st_reg        <= SWU_H_NOP;
        end
        SWU_H_NOP: begin
          // nops only retire while the cpu clock still runs
          if (bus.cpu_clk_en & nop_reg != 2'd0) begin
            bus.instr_end <= 1'b1;
            nop_reg       <= nop_reg - 2'd1;
          end
          if (nop_reg == 2'd0 & bus.cpu_clk_en) begin
            st_reg <= SWU_H_IDLE;
            o_busy <= 1'b0;
          end
        end
        default: st_reg <= SWU_H_IDLE;
      endcase
    end
  end
endmodule

// ==== test/swu_asserts.sv ====
// assertions on the host to device suspend interface
`timescale 1ns/10ps
module swu_asserts (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       instr_end,
  input wire logic       cpu_clk_en,
  input wire logic       cpu_hold,
  input wire logic       periph_clk_en,
  input wire logic       sleeping
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  sequence key_s;
    wr_en && addr == 8'h8E && wdata == 8'h55 && instr_end;
  endsequence
  sequence pd_s;
    key_s ##1 (wr_en && addr == 8'h87 && wdata[1]);
  endsequence
  sequence idle_s;
    key_s ##1 (wr_en && addr == 8'h87 && wdata[1:0] == 2'h1);
  endsequence
  key_order_a: assert property (key_s |=> wr_en && addr == 8'h87)
    else $error("mode write missing after key");
  pd_entry_a: assert property (pd_s |-> ##[1:4] sleeping)
    else $error("no power-down after keyed write");
  idle_entry_a: assert property (idle_s |-> ##[1:4]
    (!cpu_clk_en && periph_clk_en && !sleeping))
    else $error("no idle after keyed write");
  sleep_gates_a: assert property (sleeping |->
    !cpu_clk_en && !periph_clk_en)
    else $error("clock running in power-down");
  hold_gates_a: assert property (cpu_hold |-> !cpu_clk_en)
    else $error("cpu clock during warm-up");
  wake_warmup_a: assert property ($fell(sleeping) |->
    ##[0:1] cpu_hold[*8])
    else $error("wake skipped warm-up");
  release_run_a: assert property ($fell(cpu_hold) |->
    ##[0:2] cpu_clk_en)
    else $error("cpu clock not restored");
  cold_warmup_a: assert property ($rose(i_nrst) |-> cpu_hold[*8])
    else $error("no power warm-up after reset");
endmodule

// ==== test/tb_top.sv ====
// self-checking bench: host facing device, plus a bench-driven device
`timescale 1ns/10ps
module tb_top;
  localparam int PW = 20;
  localparam int RD = 2;
  logic       clk, rst_n, nrst_b, go, pdn, irq, ext, wdt, pc_overrange_event, uv, pin_n;
  logic [3:0] osc;
  logic [1:0] wmt, sflg;
  logic       wen, wsl, system_clock_monitor, ovo, uve, uvl, rpo, busy, susp;
  logic       wdr, cmon, ovi, uvlo, spin, vsel, oen, crst;
  logic [7:0] d;
  int         bad_count, check_count, n, e;
  logic [3:0] oscs [5] = '{4'h0, 4'h1, 4'hE, 4'hE, 4'h7};
  logic [1:0] wmts [5] = '{2'h0, 2'h3, 2'h1, 2'h3, 2'h0};
  swu_if bus_a();
  swu_if bus_b();
  swu_host u_swu_host (.i_clock(clk), .i_nrst(rst_n), .bus(bus_a),
    .i_go(go), .i_powerdown(pdn), .o_busy(busy), .o_suspended(susp));
  swu_device #(.PWR_LONG_CKS(PW), .RC_DIV(RD)) u_swu_device (
    .i_clock(clk), .i_nrst(rst_n), .bus(bus_a), .i_irq(irq),
    .i_ext_irq_zero(ext), .i_wdt_overflow(wdt),
    .i_pc_overrange_event(pc_overrange_event), .i_undervoltage_low(uv),
    .i_pin_reset_n(pin_n), .i_osc_type_option(osc),
    .i_osc_warmup_length_option(wmt), .i_watchdog_enable_option(wen),
    .i_watchdog_in_sleep_option(wsl),
    .i_clock_monitor_warmup_option(system_clock_monitor),
    .i_overrange_action_option(ovo), .i_undervoltage_enable_option(uve),
    .i_undervoltage_level_option(uvl), .i_reset_pin_option(rpo),
    .o_watchdog_run(), .o_clock_monitor_on(), .o_overrange_irq(),
    .o_undervoltage_level(), .o_shared_port_in(),
    .o_serial_ctrl_view_select(), .o_software_flags(), .o_osc_enable(),
    .o_cpu_reset());
  // second device takes bench-driven writes, including refused sequences
  swu_device #(.PWR_LONG_CKS(PW), .RC_DIV(RD)) u_swu_device_b (
    .i_clock(clk), .i_nrst(nrst_b), .bus(bus_b), .i_irq(irq),
    .i_ext_irq_zero(ext), .i_wdt_overflow(wdt),
    .i_pc_overrange_event(pc_overrange_event), .i_undervoltage_low(uv),
    .i_pin_reset_n(pin_n), .i_osc_type_option(osc),
    .i_osc_warmup_length_option(wmt), .i_watchdog_enable_option(wen),
    .i_watchdog_in_sleep_option(wsl),
    .i_clock_monitor_warmup_option(system_clock_monitor),
    .i_overrange_action_option(ovo), .i_undervoltage_enable_option(uve),
    .i_undervoltage_level_option(uvl), .i_reset_pin_option(rpo),
    .o_watchdog_run(wdr), .o_clock_monitor_on(cmon),
    .o_overrange_irq(ovi), .o_undervoltage_level(uvlo),
    .o_shared_port_in(spin), .o_serial_ctrl_view_select(vsel),
    .o_software_flags(sflg), .o_osc_enable(oen), .o_cpu_reset(crst));
  swu_asserts u_swu_asserts (.i_clock(clk), .i_nrst(rst_n),
    .wr_en(bus_a.wr_en), .addr(bus_a.addr), .wdata(bus_a.wdata),
    .instr_end(bus_a.instr_end), .cpu_clk_en(bus_a.cpu_clk_en),
    .cpu_hold(bus_a.cpu_hold), .periph_clk_en(bus_a.periph_clk_en),
    .sleeping(bus_a.sleeping));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  // every field set each call, so back-to-back ops never double-drive
  task automatic op(input logic w, r, input logic [7:0] a, v,
                    input logic ie);
    bus_b.wr_en = w;
    bus_b.rd_en = r;
    bus_b.addr = a;
    bus_b.wdata = v;
    bus_b.instr_end = ie;
    tick(1);
  endtask
  task automatic run_wait(input bit a, output int k);
    for (k = 0; k < 40000; k++) begin
      if (a ? (bus_a.cpu_clk_en === 1'b1 && bus_a.cpu_hold === 1'b0)
            : (bus_b.cpu_clk_en === 1'b1 && bus_b.cpu_hold === 1'b0))
        break;
      tick(1);
    end
    if (k == 40000) bad_count++;
  endtask
  function automatic int warm(input logic [3:0] o, input logic [1:0] w);
    if (o != 4'hE) return 128;
    return 1 << (w == 2'h0 ? 17 : w == 2'h1 ? 14 : w == 2'h2 ? 11 : 8);
  endfunction
  // slack covers synchronisers and rc tick phase
  function automatic logic inwin(input int k, input int ex);
    return k + 4 >= ex && k <= ex + 16;
  endfunction
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hE191));
    {rst_n, nrst_b, go, pdn, irq, ext, wdt, pc_overrange_event, uv} = '0;
    {osc, wmt, system_clock_monitor, ovo, uve, uvl, rpo} = '0;
    {pin_n, wen} = 2'b11;
    wsl = 1'($urandom);
    {bus_b.wr_en, bus_b.rd_en, bus_b.instr_end} = '0;
    {bus_b.addr, bus_b.wdata} = '0;
    repeat (10) @(posedge clk);
    #1;
    {rst_n, nrst_b} = 2'b11;
    run_wait(1, n);
    run_wait(0, n);
    for (int i = 0; i < 2; i++) begin
      pdn = i[0];
      go = 1'b1;
      for (n = 0; n < 9 && busy !== 1'b1; n++) tick(1);
      go = 1'b0;
      chk(busy, 1);
      for (n = 0; n < 20 && bus_a.cpu_clk_en !== 1'b0; n++) tick(1);
      tick(1);
      chk(bus_a.sleeping, pdn);
      chk(bus_a.periph_clk_en, !pdn);
      chk(susp, 1);
      if (pdn) ext = 1'b1;
      else irq = 1'b1;
      tick(4);
      {irq, ext} = 2'b00;
      run_wait(1, n);
      chk(bus_a.cpu_clk_en, 1);
      if (pdn) chk(inwin(n + 4, 64 * RD + 128), 1);
    end
    op(0, 1, 8'h8E, 8'h00, 0);
    chk(bus_b.rdata, 0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      op(1, 0, 8'h87, d & 8'hFC, 1);
      op(0, 1, 8'h87, 8'h00, 0);
      chk(bus_b.rdata, d & 8'hCC);
      chk(sflg, d[3:2]);
      chk(vsel, d[6]);
      d = 8'($urandom);
      op(1, 0, 8'h8E, d, 1);
      op(0, 1, 8'h8E, 8'h00, 0);
      chk(bus_b.rdata, d);
    end
    op(1, 0, 8'h8E, 8'h55, 1);
    op(0, 0, 8'h00, 8'h00, 1);
    op(1, 0, 8'h87, 8'h02, 1);
    repeat (4) op(0, 0, 8'h00, 8'h00, 0);
    chk(bus_b.sleeping, 0);
    op(0, 1, 8'h87, 8'h00, 0);
    chk(bus_b.rdata & 8'h03, 0);
    op(0, 1, 8'h8E, 8'h00, 0);
    chk(bus_b.rdata, 0);
    op(1, 0, 8'h8E, 8'h55, 1);
    op(1, 0, 8'h87, 8'h03, 1);
    repeat (3) op(0, 0, 8'h00, 8'h00, 1);
    op(0, 0, 8'h00, 8'h00, 0);
    chk(bus_b.sleeping, 1);
    chk(bus_b.periph_clk_en | oen, 0);
    chk(wdr, wen & wsl);
    ext = 1'b1;
    tick(4);
    ext = 1'b0;
    run_wait(0, n);
    chk(crst, 0);
    op(0, 1, 8'h87, 8'h00, 0);
    chk(bus_b.rdata & 8'h03, 0);
    op(0, 1, 8'h8E, 8'h00, 0);
    chk(bus_b.rdata, 0);
    chk(wdr, wen);
    for (int i = 0; i < 5; i++) begin
      osc = oscs[i];
      wmt = wmts[i];
      system_clock_monitor = 1'($urandom);
      nrst_b = 1'b0;
      tick(2);
      nrst_b = 1'b1;
      tick(5);
      chk(cmon, !system_clock_monitor);
      run_wait(0, n);
      chk(inwin(n + 5, PW * RD + warm(osc, wmt)), 1);
    end
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    chk(crst, 1);
    run_wait(0, n);
    chk(inwin(n + 1, 1000 * RD), 1);
    chk(crst, 0);
    ovo = 1'b1;
    pc_overrange_event = 1'b1;
    tick(1);
    pc_overrange_event = 1'b0;
    for (n = 0; n < 6 && ovi !== 1'b1; n++) tick(1);
    chk(ovi, 1);
    ovo = 1'b0;
    pc_overrange_event = 1'b1;
    tick(1);
    pc_overrange_event = 1'b0;
    tick(4);
    chk(bus_b.cpu_hold, 1);
    run_wait(0, n);
    uvl = 1'($urandom);
    uv = 1'b1;
    tick(6);
    chk(bus_b.cpu_hold, 0);
    chk(uvlo, uvl);
    uve = 1'b1;
    tick(6);
    chk(bus_b.cpu_hold, 1);
    uv = 1'b0;
    run_wait(0, n);
    rpo = 1'b1;
    pin_n = 1'b0;
    tick(6);
    chk(bus_b.cpu_hold, 0);
    chk(spin, 0);
    rpo = 1'b0;
    tick(6);
    chk(bus_b.cpu_hold, 1);
    pin_n = 1'b1;
    run_wait(0, n);
    chk(bus_b.cpu_clk_en, 1);
    report_and_stop();
  end
endmodule
